// ### hw/sfc_pkg.sv
// Shared constants and types for the synthesizer configuration decode.
// Assumes a single 250 MHz clock and a three-wire serial port sampled as plain inputs.
`default_nettype none

package sfc_pkg;

	// ****************************************
	// Word geometry
	// ****************************************
	localparam int WORD_W = 24;
	localparam int CODE_W = 4;
	localparam int FRAC_BASE_W = 12;
	localparam int FRAC_EXT_W = 10;
	localparam int FRAC_W = FRAC_BASE_W + FRAC_EXT_W;
	localparam int TOC_W = 14;
	localparam int GAIN_W = 4;
	localparam int SLIP_W = 2;

	// ****************************************
	// Control codes in bits 3..0
	// ****************************************
	localparam logic [CODE_W-1:0] CODE_LOOP = 4'h9;
	localparam logic [CODE_W-1:0] CODE_EXT = 4'hB;
	localparam logic [CODE_W-1:0] CODE_FAST = 4'hD;
	localparam logic [CODE_W-1:0] CODE_ACCESS = 4'h7;
	// Frequency word is recognised by bit 0 alone
	localparam int FREQ_FLAG_BIT = 0;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int LOOP_AUTOPU_BIT = 23;
	localparam int LOOP_DITHER_LSB = 16;
	localparam int LOOP_ORDER_LSB = 14;
	localparam int LOOP_DBL_BIT = 12;
	localparam int LOOP_REFOUT_BIT = 11;
	localparam int LOOP_AUXPOL_BIT = 10;
	localparam int LOOP_MAINPOL_BIT = 9;
	localparam int LOOP_AUXPRE_BIT = 8;
	localparam int EXT_DEN_LSB = 14;
	localparam int EXT_NUM_LSB = 4;
	localparam int FAST_SLIP_LSB = 22;
	localparam int FAST_GAIN_LSB = 18;
	localparam int FAST_TOC_LSB = 4;
	localparam int ACC_EXT_BIT = 21;
	localparam int ACC_FAST_BIT = 22;
	localparam int ACC_MAINPD_BIT = 17;
	localparam int ACC_AUXPD_BIT = 16;
	localparam int BASE_LSB = 4;

	// ****************************************
	// Modes
	// ****************************************
	typedef enum logic {PRE_8_9 = 1'b0, PRE_16_17 = 1'b1} sfc_prescaler_t;
	typedef enum logic [1:0] {
		MOD_4TH = 2'h0,
		MOD_OFF = 2'h1,
		MOD_2ND = 2'h2,
		MOD_3RD = 2'h3
	} sfc_mod_order_t;
	typedef enum logic [1:0] {
		DITHER_OFF = 2'h0,
		DITHER_WEAK = 2'h1,
		DITHER_STRONG = 2'h2,
		DITHER_RSVD = 2'h3
	} sfc_dither_t;

	// Decoded loop configuration as one carrier
	typedef struct packed {
		logic auto_powerup_enable;
		sfc_dither_t dither_select;
		sfc_mod_order_t modulator_order_select;
		logic ref_doubler_enable;
		logic ref_buffer_out_enable;
		logic aux_pump_polarity;
		logic main_pump_polarity;
		sfc_prescaler_t aux_prescaler_select;
	} sfc_loop_cfg_t;

	// Fastlock fields, carried but not interpreted here
	typedef struct packed {
		logic [SLIP_W-1:0] slip_reduction_select;
		logic [GAIN_W-1:0] fastlock_pump_gain;
		logic [TOC_W-1:0] fastlock_timeout;
	} sfc_fast_cfg_t;

	// ****************************************
	// Values after reset
	// ****************************************
	localparam sfc_loop_cfg_t LOOP_RESET = '{
		auto_powerup_enable: 1'b0,
		dither_select: DITHER_STRONG,
		modulator_order_select: MOD_3RD,
		ref_doubler_enable: 1'b0,
		ref_buffer_out_enable: 1'b0,
		aux_pump_polarity: 1'b1,
		main_pump_polarity: 1'b1,
		aux_prescaler_select: PRE_16_17
	};
	localparam logic [WORD_W-1:0] EXT_RESET = 24'h00000B;
	localparam logic [WORD_W-1:0] FAST_RESET = 24'h00000D;
	localparam logic [FRAC_BASE_W-1:0] BASE_RESET = 12'h000;
	localparam logic PD_RESET = 1'b0;
	localparam logic ACCESS_RESET = 1'b0;

endpackage

`default_nettype wire

// ### hw/sfc_serial_rx.sv
// Three-wire serial receiver: shifts data MSB first on serial clock rises,
// presents the word on a latch-enable rise. Pins are synchronous to clk.
`default_nettype none

module sfc_serial_rx #(
	parameter int WORD_W = sfc_pkg::WORD_W
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_le,
	output logic word_valid,
	output logic [WORD_W-1:0] word
);
	import sfc_pkg::*;

	logic ser_clk_q;
	logic ser_le_q;
	logic [WORD_W-1:0] shift_q;

	// ****************************************
	// Width check
	// ****************************************
	if (WORD_W < CODE_W + 1)
	begin : g_bad_width
		$error("sfc_serial_rx: word too narrow");
	end

	// Edge history of the serial clock and latch pins
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ser_clk_q <= 1'b0;
			ser_le_q <= 1'b0;
		end
		else
		begin
			ser_clk_q <= ser_clk;
			ser_le_q <= ser_le;
		end
	end

	// Shift only while the latch is low so a word cannot slide during the latch
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			shift_q <= '0;
		else if (ser_clk && !ser_clk_q && !ser_le)
			shift_q <= {shift_q[WORD_W-2:0], ser_data};
	end

	// Whole word only counts on the latch rise
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			word_valid <= 1'b0;
			word <= '0;
		end
		else
		begin
			word_valid <= ser_le && !ser_le_q;
			if (ser_le && !ser_le_q)
				word <= shift_q;
		end
	end

endmodule

`default_nettype wire

// ### hw/sfc_config_regs.sv
// Configuration decode for a dual-loop fractional-N synthesizer.
// Assumes a host writing 24-bit words over the three-wire port, pins synchronous to clk.
`default_nettype none

// Behaviour
// - aux prescaler select 0 picks 8/9, 1 picks 16/17.
// - main pump polarity 0 negative, 1 positive; positive after reset.
// - aux pump polarity 1 positive, 0 negative.
// - reference output high impedance when disabled, buffered reference when enabled.
// - doubler off feeds undoubled reference to both reference counters.
// - doubler on doubles reference to main-loop reference counter only.
// - modulator order codes: 0 fourth, 1 off, 2 second, 3 third.
// - dither codes: 0 off, 1 weak, 2 strong, 3 reserved.
// - with auto powerup on, frequency word write powers both loops up.
// - that write clears both stored powerdown bits.
// - chip enable low disables auto powerup.
// - access bit 0 keeps numerator 12 bits, extension ignored.
// - access bit 1 widens numerator to 22 bits using extension bits.
// - denominator likewise 12 or 22 bits by the access bit.
// - access bit 0 forces extension word to its default contents.
module sfc_config_regs (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_le,
	input wire logic chip_enable_pin,
	input wire logic ref_input_pin,
	output logic ref_output_pin,
	output logic ref_output_oe,
	output sfc_pkg::sfc_loop_cfg_t loop_cfg,
	output logic main_ref_doubled,
	output logic aux_ref_doubled,
	output logic modulator_enable,
	output logic dither_enable,
	output logic main_powerdown,
	output logic aux_powerdown,
	output logic main_powerup_pulse,
	output logic aux_powerup_pulse,
	output logic frac22_mode,
	output logic [sfc_pkg::FRAC_W-1:0] main_frac_numerator,
	output logic [sfc_pkg::FRAC_W-1:0] main_frac_denominator,
	output sfc_pkg::sfc_fast_cfg_t fast_cfg
);
	import sfc_pkg::*;

	logic word_valid;
	logic [WORD_W-1:0] word;
	logic [CODE_W-1:0] code;
	logic is_freq;
	logic powerup_fire;
	sfc_loop_cfg_t loop_q;
	logic [WORD_W-1:0] ext_q;
	logic [WORD_W-1:0] fast_q;
	logic [WORD_W-1:0] ext_eff;
	logic [WORD_W-1:0] fast_eff;
	logic acc_ext_q;
	logic acc_fast_q;
	logic main_pd_q;
	logic aux_pd_q;
	logic [FRAC_BASE_W-1:0] num_base_q;
	logic [FRAC_BASE_W-1:0] den_base_q;
	logic ref_out_q;
	logic ref_en_next;
	logic loop_wr;
	logic acc_wr;
	logic ext_wr;
	logic fast_wr;

	// ****************************************
	// Helpers
	// ****************************************

	// Join extension and base; the extension is zeroed in 12-bit mode
	function automatic logic [FRAC_W-1:0] frac_join(
		input logic wide,
		input logic [FRAC_EXT_W-1:0] ext,
		input logic [FRAC_BASE_W-1:0] base
	);
		logic [FRAC_EXT_W-1:0] upper;
		upper = wide ? ext : '0;
		return {upper, base};
	endfunction

	// One complete word that carries the wanted control code
	function automatic logic addressed(
		input logic valid,
		input logic [CODE_W-1:0] got,
		input logic [CODE_W-1:0] want
	);
		return valid && got == want;
	endfunction

	// ****************************************
	// Serial port
	// ****************************************
	sfc_serial_rx #(
		.WORD_W(WORD_W)
	) u_rx (
		.clk(clk),
		.rst_b(rst_b),
		.ser_clk(ser_clk),
		.ser_data(ser_data),
		.ser_le(ser_le),
		.word_valid(word_valid),
		.word(word)
	);

	// Address decode on the latched word
	assign code = word[CODE_W-1:0];

	// Write strobes, one per addressed word; at most one is high in any cycle
	assign loop_wr = addressed(word_valid, code, CODE_LOOP);
	assign acc_wr = addressed(word_valid, code, CODE_ACCESS);
	assign ext_wr = addressed(word_valid, code, CODE_EXT);
	assign fast_wr = addressed(word_valid, code, CODE_FAST);
	assign is_freq = word_valid && !word[FREQ_FLAG_BIT];
	// Chip enable low blocks the automatic powerup entirely
	assign powerup_fire = is_freq && loop_q.auto_powerup_enable && chip_enable_pin;

	// ****************************************
	// Loop configuration word
	// ****************************************

	// Each field lands only with a complete, correctly addressed word
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			loop_q <= LOOP_RESET;
		else if (loop_wr)
		begin
			loop_q.auto_powerup_enable <= word[LOOP_AUTOPU_BIT];
			loop_q.dither_select <= sfc_dither_t'(word[LOOP_DITHER_LSB +: 2]);
			loop_q.modulator_order_select <= sfc_mod_order_t'(word[LOOP_ORDER_LSB +: 2]);
			loop_q.ref_doubler_enable <= word[LOOP_DBL_BIT];
			loop_q.ref_buffer_out_enable <= word[LOOP_REFOUT_BIT];
			loop_q.aux_pump_polarity <= word[LOOP_AUXPOL_BIT];
			loop_q.main_pump_polarity <= word[LOOP_MAINPOL_BIT];
			loop_q.aux_prescaler_select <= sfc_prescaler_t'(word[LOOP_AUXPRE_BIT]);
		end
	end

	assign loop_cfg = loop_q;

	// ****************************************
	// Access and base word
	// ****************************************

	// Access bits and base denominator; the stored powerdown state is held in the next block
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			acc_ext_q <= ACCESS_RESET;
			acc_fast_q <= ACCESS_RESET;
			den_base_q <= BASE_RESET;
		end
		else if (acc_wr)
		begin
			acc_ext_q <= word[ACC_EXT_BIT];
			acc_fast_q <= word[ACC_FAST_BIT];
			den_base_q <= word[BASE_LSB +: FRAC_BASE_W];
		end
	end

	// Powerdown: a frequency write with auto powerup wins over nothing else,
	// since the access word and the frequency word can never land together
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			main_pd_q <= PD_RESET;
			aux_pd_q <= PD_RESET;
		end
		else if (powerup_fire)
		begin
			main_pd_q <= 1'b0;
			aux_pd_q <= 1'b0;
		end
		else if (acc_wr)
		begin
			main_pd_q <= word[ACC_MAINPD_BIT];
			aux_pd_q <= word[ACC_AUXPD_BIT];
		end
	end

	// Powerup strobes toward both loops
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			main_powerup_pulse <= 1'b0;
			aux_powerup_pulse <= 1'b0;
		end
		else
		begin
			main_powerup_pulse <= powerup_fire;
			aux_powerup_pulse <= powerup_fire;
		end
	end

	assign main_powerdown = main_pd_q;
	assign aux_powerdown = aux_pd_q;

	// ****************************************
	// Frequency word
	// ****************************************

	// Only the base numerator is taken from the frequency word here
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			num_base_q <= BASE_RESET;
		else if (is_freq)
			num_base_q <= word[BASE_LSB +: FRAC_BASE_W];
	end

	// ****************************************
	// Extension and fastlock words
	// ****************************************

	// Stored contents are kept even while access is off, but never used then
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ext_q <= EXT_RESET;
		else if (ext_wr)
			ext_q <= word;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			fast_q <= FAST_RESET;
		else if (fast_wr)
			fast_q <= word;
	end

	// Access bit off forces the default contents
	assign ext_eff = acc_ext_q ? ext_q : EXT_RESET;
	assign fast_eff = acc_fast_q ? fast_q : FAST_RESET;

	assign frac22_mode = acc_ext_q;
	assign main_frac_numerator = frac_join(acc_ext_q,
		ext_eff[EXT_NUM_LSB +: FRAC_EXT_W], num_base_q);
	assign main_frac_denominator = frac_join(acc_ext_q,
		ext_eff[EXT_DEN_LSB +: FRAC_EXT_W], den_base_q);

	assign fast_cfg.slip_reduction_select = fast_eff[FAST_SLIP_LSB +: SLIP_W];
	assign fast_cfg.fastlock_pump_gain = fast_eff[FAST_GAIN_LSB +: GAIN_W];
	assign fast_cfg.fastlock_timeout = fast_eff[FAST_TOC_LSB +: TOC_W];

	// ****************************************
	// Reference path
	// ****************************************

	// Enable as it will stand after this edge, so the copy and its enable move together
	assign ref_en_next = loop_wr ? word[LOOP_REFOUT_BIT] : loop_q.ref_buffer_out_enable;

	// Buffered reference copy; held low while the pin floats
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ref_out_q <= 1'b0;
		else
			ref_out_q <= ref_en_next && ref_input_pin;
	end

	assign ref_output_pin = ref_out_q;
	assign ref_output_oe = loop_q.ref_buffer_out_enable;

	// Doubler acts on the main-loop reference only; aux stays undoubled
	assign main_ref_doubled = loop_q.ref_doubler_enable;
	assign aux_ref_doubled = 1'b0;

	// ****************************************
	// Modulator and dither
	// ****************************************

	// Code 1 turns the modulator off; other codes pick an order
	always_comb
	begin
		unique case (loop_q.modulator_order_select)
			MOD_OFF: modulator_enable = 1'b0;
			MOD_4TH, MOD_2ND, MOD_3RD: modulator_enable = 1'b1;
		endcase
	end

	// Reserved dither code is treated as off so a bad write cannot inject noise
	always_comb
	begin
		unique case (loop_q.dither_select)
			DITHER_WEAK, DITHER_STRONG: dither_enable = 1'b1;
			DITHER_OFF, DITHER_RSVD: dither_enable = 1'b0;
		endcase
	end

endmodule

`default_nettype wire

// ### bench/sfc_config_regs_checker.sv
// Concurrent checks on the configuration decode outputs.
// Assumes it is bound onto sfc_config_regs, one clock domain.
`default_nettype none

module sfc_config_regs_checker
	import sfc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ser_le,
	input wire logic chip_enable_pin,
	input wire logic ref_input_pin,
	input wire logic ref_output_pin,
	input wire logic ref_output_oe,
	input wire sfc_pkg::sfc_loop_cfg_t loop_cfg,
	input wire logic main_ref_doubled,
	input wire logic aux_ref_doubled,
	input wire logic modulator_enable,
	input wire logic dither_enable,
	input wire logic main_powerdown,
	input wire logic aux_powerdown,
	input wire logic main_powerup_pulse,
	input wire logic aux_powerup_pulse,
	input wire logic frac22_mode,
	input wire logic [sfc_pkg::FRAC_W-1:0] main_frac_numerator,
	input wire logic [sfc_pkg::FRAC_W-1:0] main_frac_denominator
);
	// ****************************************
	// Output relations
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// Checked only after two driven cycles, so an enable change cannot confuse it
	ref_copy_a: assert property (
		ref_output_oe && $past(ref_output_oe) |-> ref_output_pin == $past(ref_input_pin))
		else $error("reference copy wrong");
	ref_enable_a: assert property (
		ref_output_oe == loop_cfg.ref_buffer_out_enable && (ref_output_oe || !ref_output_pin))
		else $error("reference enable wrong");
	doubler_a: assert property (
		main_ref_doubled == loop_cfg.ref_doubler_enable && !aux_ref_doubled)
		else $error("doubler flags wrong");
	mod_enable_a: assert property (
		modulator_enable == (loop_cfg.modulator_order_select != MOD_OFF))
		else $error("modulator enable wrong");
	dither_map_a: assert property (
		dither_enable == (loop_cfg.dither_select inside {DITHER_WEAK, DITHER_STRONG}))
		else $error("dither enable wrong");
	pulse_pair_a: assert property (
		main_powerup_pulse |-> aux_powerup_pulse ##1 !main_powerup_pulse && !aux_powerup_pulse)
		else $error("powerup pulses wrong");
	pd_clear_a: assert property (
		main_powerup_pulse |-> !main_powerdown && !aux_powerdown)
		else $error("powerdown not cleared");
	pulse_ce_a: assert property (
		main_powerup_pulse |-> $past(chip_enable_pin))
		else $error("powerup with chip disabled");
	no_ext_a: assert property (
		!frac22_mode |-> main_frac_numerator[21:12] == 0 && main_frac_denominator[21:12] == 0)
		else $error("extension bits leak");
	cfg_latch_a: assert property (
		!$stable(loop_cfg) |-> $past(ser_le, 2) || $past(ser_le, 3))
		else $error("loop config changed without latch");

	cover property (main_powerup_pulse);
	cover property (frac22_mode && main_frac_numerator[21:12] != 0);
	cover property (dither_enable && loop_cfg.dither_select == DITHER_WEAK);
endmodule

`default_nettype wire

// ### bench/sfc_host_model.sv
// Host side of the three-wire port: shifts whole 24-bit words MSB first.
// Assumes clk is the device clock; pins change just after its rising edge.
`default_nettype none

module sfc_host_model (
	input wire logic clk,
	output var logic ser_clk,
	output var logic ser_data,
	output var logic ser_le
);
	timeunit 1ns;
	timeprecision 1ps;

	// Serial clock stands low between frames
	initial
	begin
		ser_clk = 1'h0;
		ser_data = 1'h0;
		ser_le = 1'h0;
	end

	// Two cycles high and three low per bit leave margin over the one-cycle minimum
	task automatic send_word(input logic [23:0] w);
		for (int i = 23; i >= 0; i--)
		begin
			ser_data <= w[i];
			@(posedge clk);
			ser_clk <= 1'h1;
			repeat (2) @(posedge clk);
			ser_clk <= 1'h0;
			repeat (2) @(posedge clk);
		end
		// Data is released: show the inverse so a stale bit cannot pass
		ser_le <= 1'h1;
		ser_data <= ~w[0];
		repeat (2) @(posedge clk);
		ser_le <= 1'h0;
		repeat (2) @(posedge clk);
	endtask
endmodule

`default_nettype wire

// ### bench/sfc_config_regs_test.sv
// Self-checking bench for the synthesizer configuration decode.
// Assumes the host model drives the serial pins and the checker is bound.
`default_nettype none

module sfc_config_regs_test
	import sfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk;
	logic rst_b = 1'h0;
	logic chip_enable_pin = 1'h1;
	logic ref_input_pin = 1'h0;
	logic ser_clk, ser_data, ser_le, ref_output_pin, ref_output_oe, frac22_mode;
	logic main_ref_doubled, aux_ref_doubled, modulator_enable, dither_enable;
	logic main_powerdown, aux_powerdown, main_powerup_pulse, aux_powerup_pulse;
	logic [FRAC_W-1:0] num, den;
	sfc_loop_cfg_t loop_cfg;
	sfc_fast_cfg_t fast_cfg;
	int fail_count = 0;
	int checked = 0;
	int pulses = 0;

	// ****************************************
	// Clock, design and host
	// ****************************************
	initial
	begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	sfc_config_regs i_sfc_config_regs (.clk(clk), .rst_b(rst_b), .ser_clk(ser_clk),
		.ser_data(ser_data), .ser_le(ser_le), .chip_enable_pin(chip_enable_pin),
		.ref_input_pin(ref_input_pin), .ref_output_pin(ref_output_pin),
		.ref_output_oe(ref_output_oe), .loop_cfg(loop_cfg), .main_ref_doubled(main_ref_doubled),
		.aux_ref_doubled(aux_ref_doubled), .modulator_enable(modulator_enable),
		.dither_enable(dither_enable), .main_powerdown(main_powerdown),
		.aux_powerdown(aux_powerdown), .main_powerup_pulse(main_powerup_pulse),
		.aux_powerup_pulse(aux_powerup_pulse), .frac22_mode(frac22_mode),
		.main_frac_numerator(num), .main_frac_denominator(den), .fast_cfg(fast_cfg));

	sfc_host_model i_sfc_host_model (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data),
		.ser_le(ser_le));

	// Pulses are one cycle wide, so they are counted rather than sampled; both must fire
	always @(posedge clk)
		if (main_powerup_pulse === 1'h1 && aux_powerup_pulse === 1'h1)
			pulses <= pulses + 1;

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		if (fail_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic wr(input logic [23:0] w);
		i_sfc_host_model.send_word(w);
	endtask

	function automatic logic [23:0] loop_w(input logic [9:0] c);
		return {c[9], 5'h00, c[8:5], 1'h0, c[4:0], 4'h0, CODE_LOOP};
	endfunction

	// Bit 20 is kept set, as the host is expected to do
	function automatic logic [23:0] acc_w(input logic e, f, input logic [1:0] pd,
		input logic [11:0] d);
		return {1'h0, f, e, 3'h4, pd, d, CODE_ACCESS};
	endfunction

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic s_reset();
		chk(loop_cfg, LOOP_RESET);
		chk({main_powerdown, aux_powerdown, frac22_mode, ref_output_oe}, 24'h0);
		chk(num, 24'h0);
		chk(den, 24'h0);
		chk(fast_cfg, 24'h0);
	endtask

	task automatic s_loop();
		logic [9:0] c;
		wr(acc_w(1'h0, 1'h0, 2'h0, 12'h3E8));
		for (int i = 0; i < 4; i++)
		begin
			c = {1'h0, i[1:0], i[1:0], i[0], i[1], ~i[0], i[0], ~i[1]};
			wr(loop_w(c));
			chk(loop_cfg, c);
			chk({main_ref_doubled, modulator_enable, dither_enable}, {c[4], i != 1, c[7] ^ c[8]});
		end
		for (int i = 0; i < 4; i++)
		begin
			ref_input_pin <= i[0];
			repeat (2) @(posedge clk);
			chk(ref_output_pin, i[0]);
		end
		wr(loop_w(10'h000));
		chk({ref_output_oe, ref_output_pin, main_ref_doubled}, 24'h0);
	endtask

	task automatic s_frac();
		wr({10'h2A5, 10'h15A, CODE_EXT});
		wr({8'h00, 12'h123, 4'h0});
		chk(num, 22'h000123);
		chk(den, 22'h0003E8);
		wr(acc_w(1'h1, 1'h0, 2'h0, 12'h3E8));
		chk(num, {10'h15A, 12'h123});
		chk(den, {10'h2A5, 12'h3E8});
		wr({10'h3FF, 10'h3FF, CODE_EXT});
		wr({8'h00, 12'hFFF, 4'h0});
		chk(num, 22'h3FFFFF);
		wr(acc_w(1'h0, 1'h0, 2'h0, 12'h3E8));
		chk(num, 22'h000FFF);
		wr({10'h000, 10'h000, CODE_EXT});
		wr(acc_w(1'h1, 1'h0, 2'h0, 12'h3E8));
		chk(num, 22'h000FFF);
		chk(den, 22'h0003E8);
	endtask

	task automatic s_fast();
		wr({2'h2, 4'hA, 14'h2ACF, CODE_FAST});
		chk(fast_cfg, 24'h0);
		wr(acc_w(1'h0, 1'h1, 2'h0, 12'h3E8));
		chk(fast_cfg, {2'h2, 4'hA, 14'h2ACF});
	endtask

	task automatic s_power();
		wr(acc_w(1'h0, 1'h0, 2'h3, 12'h3E8));
		wr(loop_w(10'h200));
		chip_enable_pin <= 1'h0;
		wr({8'h00, 12'h001, 4'h0});
		chk({main_powerdown, aux_powerdown, pulses[7:0]}, 24'h300);
		chip_enable_pin <= 1'h1;
		wr({8'h00, 12'h002, 4'h0});
		@(posedge clk);
		chk({main_powerdown, aux_powerdown}, 24'h0);
		chk(pulses[7:0], 24'h1);
		wr(acc_w(1'h0, 1'h0, 2'h3, 12'h3E8));
		wr(24'hABCDE3);
		chk(loop_cfg, 10'h200);
		wr(loop_w(10'h000));
		wr({8'h00, 12'h003, 4'h0});
		chk({main_powerdown, aux_powerdown, pulses[7:0]}, 24'h301);
	endtask

	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		s_reset();
		s_loop();
		s_frac();
		s_fast();
		s_power();
		give_verdict();
	end
endmodule

bind sfc_config_regs sfc_config_regs_checker i_sfc_config_regs_checker (.clk(clk),
	.rst_b(rst_b), .ser_le(ser_le), .chip_enable_pin(chip_enable_pin),
	.ref_input_pin(ref_input_pin), .ref_output_pin(ref_output_pin),
	.ref_output_oe(ref_output_oe), .loop_cfg(loop_cfg), .main_ref_doubled(main_ref_doubled),
	.aux_ref_doubled(aux_ref_doubled), .modulator_enable(modulator_enable),
	.dither_enable(dither_enable), .main_powerdown(main_powerdown),
	.aux_powerdown(aux_powerdown), .main_powerup_pulse(main_powerup_pulse),
	.aux_powerup_pulse(aux_powerup_pulse), .frac22_mode(frac22_mode),
	.main_frac_numerator(main_frac_numerator), .main_frac_denominator(main_frac_denominator));

`default_nettype wire
